// >>> hdl/hftc_defines.vh
`ifndef HFTC_DEFINES_VH
`define HFTC_DEFINES_VH
// ----------------------------------------
// register indices (printed offsets, byte address is index times four)
// ----------------------------------------
`define HFTC_IDX_TXCNT_HI    8'h1D
`define HFTC_IDX_TXCNT_LO    8'h1E
`define HFTC_IDX_RATE_DISP   8'h1F
`define HFTC_IDX_CONV_RES    8'h20
`define HFTC_IDX_TRIM_CTL    8'h21
`define HFTC_IDX_IRQ_STAT    8'h30
`define HFTC_IDX_IRQ_MASK    8'h31
`define HFTC_IDX_CONTROL     8'h32
`define HFTC_IDX_ERR_CNT     8'h33
// ----------------------------------------
// fields
// ----------------------------------------
`define HFTC_RESET_BYTE      8'h00
`define HFTC_SPLIT_NONE      3'h0
`define HFTC_RATE_RESET      4'h0
`define HFTC_CTL_RESET       2'h0
`define HFTC_TRIM_SEL_BIT    7
`define HFTC_TRIM_MSB        6
`define HFTC_TRIM_LSB        3
`define HFTC_SPLIT_MSB       2
`define HFTC_CNT_LO_MSB      7
`define HFTC_CNT_LO_LSB      3
`define HFTC_RATE_MSB        7
`define HFTC_RATE_LSB        4
// interrupt status bits
`define HFTC_IRQ_PAR         0
`define HFTC_IRQ_TXDONE      1
`define HFTC_IRQ_CONV        2
`define HFTC_IRQ_RATE        3
`define HFTC_IRQ_W           4
// control register bits
`define HFTC_CTL_ANCTL       0
`define HFTC_CTL_ISO_A       1
`endif

// >>> hdl/hftc_regs.v
// Summary of operation
// - the transmit byte count is 13 bits: high register gives bits 12:5, low register bits 7:3 give bits 4:0.
// - bits 2:0 of the low count register give the bits of a trailing split byte, 000 meaning none.
// - in type A mode a nonzero split count sends a bit-oriented frame with parity generation off.
// - a wake-up request with anticollision set, card idle and nonzero split count raises the parity error interrupt.
// - bits 7:4 of the rate display hold the detected peer-to-peer bit rate, bits 3:0 read zero.
// - the converter result register holds the last conversion value, updated on each completion.
// - trim select bit 7 chooses calibration result (0) or manual code (1) for the trim switches.
// - with manual trim each set bit of the code in bits 6:3 turns on that transistor in both pin groups.
// - all writable registers reset to zero at power-up and on the set-default command.
// - the rate display and converter result clear to zero at power-up and on set-default.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "hftc_defines.vh"
module hftc_regs
  (
    input  wire        clock_in,
    input  wire        rst_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [31:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    input  wire        set_default_in,
    input  wire        tx_start_in,
    input  wire        wake_req_in,
    input  wire        card_idle_in,
    input  wire        conv_done_in,
    input  wire [7:0]  conv_data_in,
    input  wire        rate_valid_in,
    input  wire [3:0]  rate_code_in,
    input  wire [3:0]  calib_trim_in,
    input  wire        tx_done_in,
    output reg  [3:0]  first_trim_pin_group_out,
    output reg  [3:0]  second_trim_pin_group_out,
    output reg  [12:0] tx_count_out,
    output reg  [2:0]  tx_split_out,
    output reg         tx_no_parity_out,
    output reg         irq_out
  );
  // ----------------------------------------
  // pin input synchronisers
  // ----------------------------------------
  wire       card_idle_s;
  wire [3:0] calib_trim_s;
  hftc_sync u_idle
  (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .d_in     (card_idle_in),
    .q_out    (card_idle_s)
  );
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_trim_sync
      hftc_sync u_trim
      (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .d_in     (calib_trim_in[gi]),
        .q_out    (calib_trim_s[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] cnt_hi_q;
  reg [7:0] cnt_lo_q;
  reg [3:0] rate_q;
  reg [7:0] conv_q;
  reg [7:0] trim_ctl_q;
  reg [`HFTC_IRQ_W-1:0] irq_stat_q;
  reg [`HFTC_IRQ_W-1:0] irq_mask_q;
  reg [1:0] ctl_q;
  reg [7:0] par_err_cnt_q;

  function is_idx;
    input [31:0] addr;
    input [7:0]  idx;
    begin
      is_idx = (addr[31:2] == {22'h000000, idx}) && (addr[1:0] == 2'h0);
    end
  endfunction

  // one wait state: pready is registered and rises the cycle after the access phase begins
  wire acc    = psel_in && penable_in && !pready_out;
  wire wr     = acc && pwrite_in;
  wire rd     = acc && !pwrite_in;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // a misaligned or unlisted address hits nothing and is answered with an error
  wire hit_cnt_hi   = is_idx(paddr_in, `HFTC_IDX_TXCNT_HI);
  wire hit_cnt_lo   = is_idx(paddr_in, `HFTC_IDX_TXCNT_LO);
  wire hit_rate     = is_idx(paddr_in, `HFTC_IDX_RATE_DISP);
  wire hit_conv     = is_idx(paddr_in, `HFTC_IDX_CONV_RES);
  wire hit_trim     = is_idx(paddr_in, `HFTC_IDX_TRIM_CTL);
  wire hit_irq_stat = is_idx(paddr_in, `HFTC_IDX_IRQ_STAT);
  wire hit_irq_mask = is_idx(paddr_in, `HFTC_IDX_IRQ_MASK);
  wire hit_control  = is_idx(paddr_in, `HFTC_IDX_CONTROL);
  wire hit_err_cnt  = is_idx(paddr_in, `HFTC_IDX_ERR_CNT);
  wire mapped       = hit_cnt_hi || hit_cnt_lo || hit_rate || hit_conv || hit_trim
                   || hit_irq_stat || hit_irq_mask || hit_control || hit_err_cnt;

  // ----------------------------------------
  // live count fields and parity event
  // ----------------------------------------
  wire [12:0] count_live = {cnt_hi_q, cnt_lo_q[`HFTC_CNT_LO_MSB:`HFTC_CNT_LO_LSB]};
  wire [2:0]  split_live = cnt_lo_q[`HFTC_SPLIT_MSB:0];
  // parity error when anticollision is on, card idle and a split byte is set
  wire par_evt = wake_req_in && ctl_q[`HFTC_CTL_ANCTL] && card_idle_s
              && (split_live != `HFTC_SPLIT_NONE);
  wire [`HFTC_IRQ_W-1:0] events = {rate_valid_in, conv_done_in, tx_done_in, par_evt};

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_hi_q   <= `HFTC_RESET_BYTE;
      cnt_lo_q   <= `HFTC_RESET_BYTE;
      trim_ctl_q <= `HFTC_RESET_BYTE;
      irq_mask_q <= {`HFTC_IRQ_W{1'b0}};
      ctl_q      <= `HFTC_CTL_RESET;
    end
    else if (set_default_in)
    begin
      cnt_hi_q   <= `HFTC_RESET_BYTE;
      cnt_lo_q   <= `HFTC_RESET_BYTE;
      trim_ctl_q <= `HFTC_RESET_BYTE;
      irq_mask_q <= {`HFTC_IRQ_W{1'b0}};
      ctl_q      <= `HFTC_CTL_RESET;
    end
    else
    begin
      if (wr && hit_cnt_hi)
        cnt_hi_q <= pwdata_in[7:0];
      if (wr && hit_cnt_lo)
        cnt_lo_q <= pwdata_in[7:0];
      // low three bits are unused and kept at zero
      if (wr && hit_trim)
        trim_ctl_q <= {pwdata_in[7:3], 3'h0};
      if (wr && hit_irq_mask)
        irq_mask_q <= pwdata_in[`HFTC_IRQ_W-1:0];
      if (wr && hit_control)
        ctl_q <= pwdata_in[1:0];
    end
  end

  // ----------------------------------------
  // read-only displays
  // ----------------------------------------
  // hardware updates these; bus writes to them are dropped without an error
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rate_q <= `HFTC_RATE_RESET;
      conv_q <= `HFTC_RESET_BYTE;
    end
    else if (set_default_in)
    begin
      rate_q <= `HFTC_RATE_RESET;
      conv_q <= `HFTC_RESET_BYTE;
    end
    else
    begin
      if (conv_done_in)
        conv_q <= conv_data_in;
      if (rate_valid_in)
        rate_q <= rate_code_in;
    end
  end

  // ----------------------------------------
  // interrupt status and parity error count
  // ----------------------------------------
  // read clears, but an event in the same cycle wins so no event is lost
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_stat_q    <= {`HFTC_IRQ_W{1'b0}};
      par_err_cnt_q <= `HFTC_RESET_BYTE;
    end
    else if (set_default_in)
    begin
      irq_stat_q    <= {`HFTC_IRQ_W{1'b0}};
      par_err_cnt_q <= `HFTC_RESET_BYTE;
    end
    else
    begin
      if (rd && hit_irq_stat)
        irq_stat_q <= events;
      else
        irq_stat_q <= irq_stat_q | events;
      // the counter wraps; software compares successive readings
      if (par_evt)
        par_err_cnt_q <= par_err_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  reg [7:0] rdata;
  always @*
  begin
    rdata = `HFTC_RESET_BYTE;
    if (hit_cnt_hi)
      rdata = cnt_hi_q;
    if (hit_cnt_lo)
      rdata = cnt_lo_q;
    if (hit_rate)
      rdata = {rate_q, 4'h0};
    if (hit_conv)
      rdata = conv_q;
    if (hit_trim)
      rdata = trim_ctl_q;
    if (hit_irq_stat)
      rdata = {4'h0, irq_stat_q};
    if (hit_irq_mask)
      rdata = {4'h0, irq_mask_q};
    if (hit_control)
      rdata = {6'h00, ctl_q};
    if (hit_err_cnt)
      rdata = par_err_cnt_q;
  end

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end
    else
    begin
      pready_out  <= acc;
      pslverr_out <= acc && !mapped;
      if (rd)
        prdata_out <= {24'h000000, rdata};
      else if (!acc)
        prdata_out <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // trim pins and interrupt
  // ----------------------------------------
  wire [3:0] trim_sel = trim_ctl_q[`HFTC_TRIM_SEL_BIT]
                        ? trim_ctl_q[`HFTC_TRIM_MSB:`HFTC_TRIM_LSB]
                        : calib_trim_s;
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      first_trim_pin_group_out  <= 4'h0;
      second_trim_pin_group_out <= 4'h0;
      irq_out                   <= 1'b0;
    end
    else
    begin
      first_trim_pin_group_out  <= trim_sel;
      second_trim_pin_group_out <= trim_sel;
      irq_out                   <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------
  // transmit capture
  // ----------------------------------------
  wire [12:0] snap_count;
  wire [2:0]  snap_split;
  wire        snap_nopar;
  hftc_tx_snap u_snap
  (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .clear_in      (set_default_in),
    .start_in      (tx_start_in),
    .count_in      (count_live),
    .split_in      (split_live),
    .iso_a_in      (ctl_q[`HFTC_CTL_ISO_A]),
    .count_out     (snap_count),
    .split_out     (snap_split),
    .no_parity_out (snap_nopar)
  );
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_count_out     <= 13'h0000;
      tx_split_out     <= `HFTC_SPLIT_NONE;
      tx_no_parity_out <= 1'b0;
    end
    else
    begin
      tx_count_out     <= snap_count;
      tx_split_out     <= snap_split;
      tx_no_parity_out <= snap_nopar;
    end
  end
endmodule // hftc_regs
`default_nettype wire

// >>> hdl/hftc_sync.v
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser for a level from outside the clock domain
module hftc_sync
  (
    input  wire clock_in,
    input  wire rst_in,
    input  wire d_in,
    output wire q_out
  );
  reg meta_q;
  reg sync_q;
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end
  assign q_out = sync_q;
endmodule // hftc_sync
`default_nettype wire

// >>> hdl/hftc_tx_snap.v
`timescale 1ns/1ns
`default_nettype none
`include "hftc_defines.vh"
// latches byte count and split bits when a transmit command starts
module hftc_tx_snap
  (
    input  wire        clock_in,
    input  wire        rst_in,
    input  wire        clear_in,
    input  wire        start_in,
    input  wire [12:0] count_in,
    input  wire [2:0]  split_in,
    input  wire        iso_a_in,
    output reg  [12:0] count_out,
    output reg  [2:0]  split_out,
    output reg         no_parity_out
  );
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count_out     <= 13'h0000;
      split_out     <= `HFTC_SPLIT_NONE;
      no_parity_out <= 1'b0;
    end
    else if (clear_in)
    begin
      count_out     <= 13'h0000;
      split_out     <= `HFTC_SPLIT_NONE;
      no_parity_out <= 1'b0;
    end
    else if (start_in)
    begin
      count_out     <= count_in;
      split_out     <= split_in;
      // partial last byte in type A means bit-oriented frame without parity
      no_parity_out <= iso_a_in && (split_in != `HFTC_SPLIT_NONE);
    end
  end
endmodule // hftc_tx_snap
`default_nettype wire

// >>> verif/hftc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module hftc_checker
  (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [31:0] prdata_out,
    input wire logic        set_default_in,
    input wire logic        tx_start_in,
    input wire logic [12:0] tx_count_out,
    input wire logic [2:0]  tx_split_out,
    input wire logic        tx_no_parity_out,
    input wire logic [3:0]  first_trim_pin_group_out,
    input wire logic [3:0]  second_trim_pin_group_out
  );
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  chk_ready_after: assert property
    (psel_in && penable_in && !pready_out |=> pready_out) else $error("no ready");
  chk_ready_pulse: assert property
    (pready_out |=> !pready_out) else $error("ready held");
  chk_idle_data: assert property
    (!pready_out |-> prdata_out == 32'h0) else $error("data outside access");
  chk_err_zero: assert property
    (pready_out && pslverr_out |-> prdata_out == 32'h0) else $error("error read data");
  chk_trim_pair: assert property
    (first_trim_pin_group_out == second_trim_pin_group_out) else $error("trim groups differ");
  chk_cap_hold: assert property
    (!tx_start_in && !$past(tx_start_in) && !set_default_in && !$past(set_default_in)
     |=> $stable(tx_count_out) && $stable(tx_split_out)) else $error("count moved");
  chk_dflt_clear: assert property
    (set_default_in |-> ##[1:2] (tx_count_out == 13'h0 && tx_split_out == 3'h0
     && !tx_no_parity_out)) else $error("default not cleared");
  chk_split_parity: assert property
    (tx_no_parity_out |-> tx_split_out != 3'h0) else $error("parity off without split");
endmodule // hftc_checker
`default_nettype wire

// >>> verif/hftc_host.sv
`timescale 1ns/1ns
`default_nettype none
module hftc_host
  (
    input  wire logic        clock_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in,
    input  wire logic [31:0] prdata_in,
    output var  logic        psel_out,
    output var  logic        penable_out,
    output var  logic        pwrite_out,
    output var  logic [31:0] paddr_out,
    output var  logic [31:0] pwdata_out
  );
  initial
  begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 32'h0;
    pwdata_out = 32'h0;
  end
  // entering on a fresh edge keeps one idle cycle between transfers
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clock_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= {22'h0, idx, 2'h0};
    pwdata_out <= d;
    @(posedge clock_in);
    penable_out <= 1'b1;
    @(posedge clock_in);
    while (pready_in !== 1'b1)
      @(posedge clock_in);
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule // hftc_host
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clock_in = 1'b0, rst_in = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, irq, no_par, errv;
  logic [31:0] paddr, pwdata, prdata, rdv;
  logic        set_default = 0, tx_start = 0, wake_req = 0, card_idle = 0;
  logic        conv_done = 0, rate_valid = 0, tx_done = 0;
  logic [7:0]  conv_data = 8'h00;
  logic [3:0]  rate_code = 4'h0, calib_trim = 4'h0, trim1, trim2;
  logic [12:0] tx_count;
  logic [2:0]  tx_split;
  int          fails = 0, n_compared = 0, cyc = 0;
  always #4 clock_in = ~clock_in;
  hftc_host u_host (.clock_in(clock_in), .pready_in(pready), .pslverr_in(pslverr),
    .prdata_in(prdata), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  hftc_regs u_hftc_regs (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .set_default_in(set_default), .tx_start_in(tx_start), .wake_req_in(wake_req),
    .card_idle_in(card_idle), .conv_done_in(conv_done), .conv_data_in(conv_data),
    .rate_valid_in(rate_valid), .rate_code_in(rate_code), .calib_trim_in(calib_trim),
    .tx_done_in(tx_done), .first_trim_pin_group_out(trim1), .second_trim_pin_group_out(trim2),
    .tx_count_out(tx_count), .tx_split_out(tx_split), .tx_no_parity_out(no_par),
    .irq_out(irq));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    u_host.xfer(1'b1, idx, d, rdv, errv);
  endtask
  task automatic rd(input logic [7:0] idx);
    u_host.xfer(1'b0, idx, 32'h0, rdv, errv);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic start_tx();
    @(posedge clock_in);
    tx_start <= 1'b1;
    @(posedge clock_in);
    tx_start <= 1'b0;
    tick(2);
  endtask
  task automatic all_zero();
    for (int i = 8'h1D; i <= 8'h21; i++)
    begin
      rd(i[7:0]);
      chk(rdv, 32'h0);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_count();
    wr(8'h1D, 32'hFF);
    wr(8'h1E, 32'hFF);
    start_tx();
    chk(tx_count, 32'h1FFF);
    chk(tx_split, 32'h7);
    chk(no_par, 32'h0);
    wr(8'h1D, 32'h12);
    tick(2);
    chk(tx_count, 32'h1FFF);
    wr(8'h32, 32'h3);
    wr(8'h1E, 32'h2B);
    start_tx();
    chk(tx_count, 32'h245);
    chk(no_par, 32'h1);
    wr(8'h1E, 32'h28);
    start_tx();
    chk(no_par, 32'h0);
    wr(8'h1E, 32'h2B);
  endtask
  task automatic t_parity();
    wr(8'h31, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      card_idle <= k[0];
      tick(4);
      wake_req <= 1'b1;
      @(posedge clock_in);
      wake_req <= 1'b0;
      tick(3);
      chk(irq, k);
      rd(8'h30);
      chk(rdv, k);
    end
    tick(3);
    chk(irq, 32'h0);
    rd(8'h33);
    chk(rdv, 32'h1);
  endtask
  task automatic t_sense();
    rate_valid <= 1'b1;
    rate_code <= 4'hA;
    conv_done <= 1'b1;
    conv_data <= 8'h5C;
    tx_done <= 1'b1;
    @(posedge clock_in);
    rate_valid <= 1'b0;
    conv_done <= 1'b0;
    tx_done <= 1'b0;
    rd(8'h1F);
    chk(rdv, 32'hA0);
    rd(8'h20);
    chk(rdv, 32'h5C);
    rd(8'h30);
    chk(rdv, 32'hE);
    conv_done <= 1'b1;
    conv_data <= 8'hE3;
    @(posedge clock_in);
    conv_done <= 1'b0;
    rd(8'h20);
    chk(rdv, 32'hE3);
  endtask
  task automatic t_trim();
    calib_trim <= 4'h5;
    tick(5);
    chk(trim1, 32'h5);
    wr(8'h21, 32'hB0);
    tick(2);
    chk(trim1, 32'h6);
    chk(trim2, 32'h6);
    rd(8'h21);
    chk(rdv, 32'hB0);
    rd(8'h40);
    chk(errv, 32'h1);
  endtask
  task automatic t_default();
    @(posedge clock_in);
    set_default <= 1'b1;
    @(posedge clock_in);
    set_default <= 1'b0;
    tick(3);
    all_zero();
    for (int i = 8'h30; i <= 8'h33; i++)
    begin
      rd(i[7:0]);
      chk(rdv, 32'h0);
    end
    chk(tx_count, 32'h0);
    chk(trim1, 32'h5);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      report_and_stop();
    end
  end
  initial
  begin
    tick(12);
    rst_in <= 1'b0;
    all_zero();
    t_count();
    t_parity();
    t_sense();
    t_trim();
    t_default();
    report_and_stop();
  end
endmodule // tb
bind hftc_regs hftc_checker u_chk (.clock_in(clock_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .prdata_out(prdata_out), .set_default_in(set_default_in),
  .tx_start_in(tx_start_in), .tx_count_out(tx_count_out), .tx_split_out(tx_split_out),
  .tx_no_parity_out(tx_no_parity_out), .first_trim_pin_group_out(first_trim_pin_group_out),
  .second_trim_pin_group_out(second_trim_pin_group_out));
`default_nettype wire
